// File: inc/psalu_consts.vh
// opcode encodings, register file shape and saturation limits
// assumes inclusion by the datapath and its lane module
`ifndef PSALU_CONSTS_VH
`define PSALU_CONSTS_VH
`define PSALU_OP_W 5
`define PSALU_OP_NOP 5'h00
`define PSALU_OP_ADD_BYTES_WRAP 5'h01
`define PSALU_OP_ADD_WORDS_WRAP 5'h02
`define PSALU_OP_ADD_DOUBLEWORDS_WRAP 5'h03
`define PSALU_OP_SUB_BYTES_WRAP 5'h04
`define PSALU_OP_SUB_WORDS_WRAP 5'h05
`define PSALU_OP_SUB_DOUBLEWORDS_WRAP 5'h06
`define PSALU_OP_ADD_BYTES_SIGNED_SAT 5'h07
`define PSALU_OP_ADD_WORDS_SIGNED_SAT 5'h08
`define PSALU_OP_SUB_BYTES_SIGNED_SAT 5'h09
`define PSALU_OP_SUB_WORDS_SIGNED_SAT 5'h0a
`define PSALU_OP_ADD_BYTES_UNSIGNED_SAT 5'h0b
`define PSALU_OP_ADD_WORDS_UNSIGNED_SAT 5'h0c
`define PSALU_OP_SUB_BYTES_UNSIGNED_SAT 5'h0d
`define PSALU_OP_SUB_WORDS_UNSIGNED_SAT 5'h0e
`define PSALU_OP_MULTIPLY_WORDS_KEEP_HIGH 5'h0f
`define PSALU_OP_MULTIPLY_WORDS_KEEP_LOW 5'h10
`define PSALU_OP_MULTIPLY_ADD_WORD_PAIRS 5'h11
`define PSALU_OP_MOVE_32_LOAD 5'h12
`define PSALU_OP_MOVE_32_STORE 5'h13
`define PSALU_OP_MOVE_32_FROM_GPR 5'h14
`define PSALU_OP_MOVE_32_TO_GPR 5'h15
`define PSALU_OP_MOVE_64_LOAD 5'h16
`define PSALU_OP_MOVE_64_STORE 5'h17
`define PSALU_OP_MOVE_64_REG 5'h18
`define PSALU_MODE_WRAP 2'h0
`define PSALU_MODE_SSAT 2'h1
`define PSALU_MODE_USAT 2'h2
`define PSALU_SIZE_BYTE 2'h0
`define PSALU_SIZE_WORD 2'h1
`define PSALU_SIZE_DWORD 2'h2
`define PSALU_NREGS 8
`define PSALU_RIDX_W 3
`define PSALU_FEATURE_BIT 23
`define PSALU_SB_MAX 8'h7f
`define PSALU_SB_MIN 8'h80
`define PSALU_SW_MAX 16'h7fff
`define PSALU_SW_MIN 16'h8000
`define PSALU_UB_MAX 8'hff
`define PSALU_UB_MIN 8'h00
`define PSALU_UW_MAX 16'hffff
`define PSALU_UW_MIN 16'h0000
`define PSALU_REG_RESET 64'h0000_0000_0000_0000
`endif

// File: core/psalu_lane.v
// one byte lane of the packed adder with carry out and signed overflow flag
// assumes neighbour carry in is only used when lane joining is allowed
`timescale 1ns/1ps
`default_nettype none
`include "psalu_consts.vh"
module psalu_lane (
    input wire [7:0] a,
    input wire [7:0] b,
    input wire sub,
    input wire cin,
    output wire [7:0] sum,
    output wire cout,
    output wire ovf_s
);
    wire [7:0] bx;
    wire [8:0] full;
    assign bx = sub ? ~b : b;
    assign full = {1'b0, a} + {1'b0, bx} + {8'h00, cin};
    assign sum = full[7:0];
    assign cout = full[8];
    assign ovf_s = (a[7] == bx[7]) && (sum[7] != a[7]);
endmodule
`default_nettype wire

// File: core/psalu_top.v
// packed saturating integer datapath with eight 64-bit packed registers
// assumes decode issues at most one op per cycle with valid operands
// How it works
// (RULE1) wrap mode keeps only low result bits
// (RULE2) signed byte clamps to 7f and 80
// (RULE3) signed word clamps to 7fff and 8000
// (RULE4) unsigned byte clamps to ff and 00
// (RULE5) unsigned word clamps to ffff and 0000
// (RULE6) no exception, status flags untouched
// (RULE7) 32-bit moves memory or gpr both ways
// (RULE8) 64-bit moves memory or register both ways
// (RULE9) wrap add/sub on byte word doubleword
// (RULE10) signed sat add/sub byte and word only
// (RULE11) unsigned sat add/sub byte and word only
// (RULE12) signed word multiply keeps high or low
// (RULE13) multiply-add sums adjacent word product pairs
// (RULE14) group enabled only by feature bit 23
// (RULE15) eight 64-bit packed registers
// (RULE16) least element at lowest memory address
// (RULE17) carries and clamps stay inside lanes
`timescale 1ns/1ps
`default_nettype none
`include "psalu_consts.vh"
module psalu_top (
    input wire clk_sys,
    input wire rst,
    input wire issue_valid,
    input wire [`PSALU_OP_W-1:0] issue_op,
    input wire [`PSALU_RIDX_W-1:0] dst_idx,
    input wire [`PSALU_RIDX_W-1:0] src_idx,
    input wire [31:0] feature_word,
    input wire [63:0] mem_rdata,
    input wire [31:0] gpr_rdata,
    output reg done,
    output reg invalid_op,
    output reg [63:0] mem_wdata,
    output reg [7:0] mem_wbyte_en,
    output reg mem_wvalid,
    output reg [31:0] gpr_wdata,
    output reg gpr_wvalid,
    output reg [63:0] result,
    output reg status_flags_we,
    output reg exception
);
    // (RULE15) packed register file
    reg [63:0] packed_reg [0:`PSALU_NREGS-1];
    wire [63:0] opd;
    wire [63:0] ops;
    assign opd = packed_reg[dst_idx];
    assign ops = packed_reg[src_idx];

    reg is_arith;
    reg sub;
    reg [1:0] mode;
    reg [1:0] size;
    reg legal;
    always @* begin
        is_arith = 1'b1;
        sub = 1'b0;
        mode = `PSALU_MODE_WRAP;
        size = `PSALU_SIZE_BYTE;
        legal = 1'b1;
        // (RULE9) (RULE10) (RULE11) decode size and mode
        case (issue_op)
            `PSALU_OP_ADD_BYTES_WRAP: size = `PSALU_SIZE_BYTE;
            `PSALU_OP_ADD_WORDS_WRAP: size = `PSALU_SIZE_WORD;
            `PSALU_OP_ADD_DOUBLEWORDS_WRAP: size = `PSALU_SIZE_DWORD;
            `PSALU_OP_SUB_BYTES_WRAP: sub = 1'b1;
            `PSALU_OP_SUB_WORDS_WRAP: begin
                sub = 1'b1;
                size = `PSALU_SIZE_WORD;
            end
            `PSALU_OP_SUB_DOUBLEWORDS_WRAP: begin
                sub = 1'b1;
                size = `PSALU_SIZE_DWORD;
            end
            `PSALU_OP_ADD_BYTES_SIGNED_SAT: mode = `PSALU_MODE_SSAT;
            `PSALU_OP_ADD_WORDS_SIGNED_SAT: begin
                mode = `PSALU_MODE_SSAT;
                size = `PSALU_SIZE_WORD;
            end
            `PSALU_OP_SUB_BYTES_SIGNED_SAT: begin
                mode = `PSALU_MODE_SSAT;
                sub = 1'b1;
            end
            `PSALU_OP_SUB_WORDS_SIGNED_SAT: begin
                mode = `PSALU_MODE_SSAT;
                sub = 1'b1;
                size = `PSALU_SIZE_WORD;
            end
            `PSALU_OP_ADD_BYTES_UNSIGNED_SAT: mode = `PSALU_MODE_USAT;
            `PSALU_OP_ADD_WORDS_UNSIGNED_SAT: begin
                mode = `PSALU_MODE_USAT;
                size = `PSALU_SIZE_WORD;
            end
            `PSALU_OP_SUB_BYTES_UNSIGNED_SAT: begin
                mode = `PSALU_MODE_USAT;
                sub = 1'b1;
            end
            `PSALU_OP_SUB_WORDS_UNSIGNED_SAT: begin
                mode = `PSALU_MODE_USAT;
                sub = 1'b1;
                size = `PSALU_SIZE_WORD;
            end
            `PSALU_OP_MULTIPLY_WORDS_KEEP_HIGH,
            `PSALU_OP_MULTIPLY_WORDS_KEEP_LOW,
            `PSALU_OP_MULTIPLY_ADD_WORD_PAIRS,
            `PSALU_OP_MOVE_32_LOAD,
            `PSALU_OP_MOVE_32_STORE,
            `PSALU_OP_MOVE_32_FROM_GPR,
            `PSALU_OP_MOVE_32_TO_GPR,
            `PSALU_OP_MOVE_64_LOAD,
            `PSALU_OP_MOVE_64_STORE,
            `PSALU_OP_MOVE_64_REG: is_arith = 1'b0;
            default: begin
                is_arith = 1'b0;
                legal = 1'b0;
            end
        endcase
    end

    // byte lanes with carry joined only inside an element
    wire [7:0] cin;
    wire [7:0] cout;
    wire [7:0] ovf;
    wire [63:0] raw;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_lane
            wire join_prev;
            // (RULE17) carry stops at element edge
            if (gi == 0) begin : g_first
                assign join_prev = 1'b0;
            end else if (gi % 4 == 0) begin : g_dw
                assign join_prev = 1'b0;
            end else if (gi % 2 == 0) begin : g_w
                assign join_prev = (size == `PSALU_SIZE_DWORD);
            end else begin : g_b
                assign join_prev = (size != `PSALU_SIZE_BYTE);
            end
            if (gi == 0) begin : g_c0
                assign cin[gi] = sub;
            end else begin : g_cn
                assign cin[gi] = join_prev ? cout[gi-1] : sub;
            end
            psalu_lane u_lane (
                .a(opd[8*gi+7:8*gi]),
                .b(ops[8*gi+7:8*gi]),
                .sub(sub),
                .cin(cin[gi]),
                .sum(raw[8*gi+7:8*gi]),
                .cout(cout[gi]),
                .ovf_s(ovf[gi])
            );
        end
    endgenerate

    // saturation per element
    reg [63:0] sat;
    integer i;
    integer ri;
    reg uo;
    always @* begin
        sat = raw;
        uo = 1'b0;
        i = 0;
        // (RULE1) wrap keeps raw low bits
        if (mode == `PSALU_MODE_SSAT && size == `PSALU_SIZE_BYTE) begin
            for (i = 0; i < 8; i = i + 1) begin
                // (RULE2) signed byte clamp
                if (ovf[i])
                    sat[8*i +: 8] = opd[8*i+7] ? `PSALU_SB_MIN :
                        `PSALU_SB_MAX;
            end
        end else if (mode == `PSALU_MODE_SSAT) begin
            for (i = 0; i < 4; i = i + 1) begin
                // (RULE3) signed word clamp
                if (ovf[2*i+1])
                    sat[16*i +: 16] = opd[16*i+15] ? `PSALU_SW_MIN :
                        `PSALU_SW_MAX;
            end
        end else if (mode == `PSALU_MODE_USAT &&
                     size == `PSALU_SIZE_BYTE) begin
            for (i = 0; i < 8; i = i + 1) begin
                // (RULE4) unsigned byte clamp
                uo = cout[i] ^ sub;
                if (uo)
                    sat[8*i +: 8] = sub ? `PSALU_UB_MIN : `PSALU_UB_MAX;
            end
        end else if (mode == `PSALU_MODE_USAT) begin
            for (i = 0; i < 4; i = i + 1) begin
                // (RULE5) unsigned word clamp
                uo = cout[2*i+1] ^ sub;
                if (uo)
                    sat[16*i +: 16] = sub ? `PSALU_UW_MIN :
                        `PSALU_UW_MAX;
            end
        end
    end

    // signed word products
    wire signed [31:0] prod [0:3];
    wire [63:0] mul_hi;
    wire [63:0] mul_lo;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_mul
            // (RULE12) signed word product
            assign prod[gi] = $signed(opd[16*gi+15:16*gi]) *
                $signed(ops[16*gi+15:16*gi]);
            assign mul_hi[16*gi+15:16*gi] = prod[gi][31:16];
            assign mul_lo[16*gi+15:16*gi] = prod[gi][15:0];
        end
    endgenerate
    wire [31:0] madd_lo;
    wire [31:0] madd_hi;
    // (RULE13) pairwise product sums
    assign madd_lo = prod[0] + prod[1];
    assign madd_hi = prod[2] + prod[3];

    // (RULE14) feature gate
    wire enabled;
    assign enabled = feature_word[`PSALU_FEATURE_BIT];

    always @(posedge clk_sys) begin
        if (rst) begin
            done <= 1'b0;
            invalid_op <= 1'b0;
            mem_wdata <= `PSALU_REG_RESET;
            mem_wbyte_en <= 8'h00;
            mem_wvalid <= 1'b0;
            gpr_wdata <= 32'h0000_0000;
            gpr_wvalid <= 1'b0;
            result <= `PSALU_REG_RESET;
            status_flags_we <= 1'b0;
            exception <= 1'b0;
            for (ri = 0; ri < `PSALU_NREGS; ri = ri + 1)
                packed_reg[ri] <= `PSALU_REG_RESET;
        end else begin
            // (RULE6) flags and exception never raised
            status_flags_we <= 1'b0;
            exception <= 1'b0;
            done <= 1'b0;
            invalid_op <= 1'b0;
            mem_wvalid <= 1'b0;
            mem_wbyte_en <= 8'h00;
            gpr_wvalid <= 1'b0;
            if (issue_valid && (!enabled || !legal)) begin
                // (RULE14) refuse without feature
                invalid_op <= 1'b1;
            end else if (issue_valid) begin
                done <= 1'b1;
                if (is_arith) begin
                    packed_reg[dst_idx] <= sat;
                    result <= sat;
                end else begin
                    case (issue_op)
                        `PSALU_OP_MULTIPLY_WORDS_KEEP_HIGH: begin
                            packed_reg[dst_idx] <= mul_hi;
                            result <= mul_hi;
                        end
                        `PSALU_OP_MULTIPLY_WORDS_KEEP_LOW: begin
                            packed_reg[dst_idx] <= mul_lo;
                            result <= mul_lo;
                        end
                        `PSALU_OP_MULTIPLY_ADD_WORD_PAIRS: begin
                            packed_reg[dst_idx] <= {madd_hi, madd_lo};
                            result <= {madd_hi, madd_lo};
                        end
                        // (RULE7) (RULE16) 32-bit load, low lanes
                        `PSALU_OP_MOVE_32_LOAD: begin
                            packed_reg[dst_idx] <= {32'h0000_0000,
                                mem_rdata[31:0]};
                            result <= {32'h0000_0000, mem_rdata[31:0]};
                        end
                        `PSALU_OP_MOVE_32_STORE: begin
                            mem_wdata <= {32'h0000_0000, ops[31:0]};
                            mem_wbyte_en <= 8'h0f;
                            mem_wvalid <= 1'b1;
                            result <= {32'h0000_0000, ops[31:0]};
                        end
                        // (RULE7) gpr transfers
                        `PSALU_OP_MOVE_32_FROM_GPR: begin
                            packed_reg[dst_idx] <= {32'h0000_0000,
                                gpr_rdata};
                            result <= {32'h0000_0000, gpr_rdata};
                        end
                        `PSALU_OP_MOVE_32_TO_GPR: begin
                            gpr_wdata <= ops[31:0];
                            gpr_wvalid <= 1'b1;
                            result <= {32'h0000_0000, ops[31:0]};
                        end
                        // (RULE8) (RULE16) 64-bit transfers
                        `PSALU_OP_MOVE_64_LOAD: begin
                            packed_reg[dst_idx] <= mem_rdata;
                            result <= mem_rdata;
                        end
                        `PSALU_OP_MOVE_64_STORE: begin
                            mem_wdata <= ops;
                            mem_wbyte_en <= 8'hff;
                            mem_wvalid <= 1'b1;
                            result <= ops;
                        end
                        `PSALU_OP_MOVE_64_REG: begin
                            packed_reg[dst_idx] <= ops;
                            result <= ops;
                        end
                        default: begin
                            result <= result;
                        end
                    endcase
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/psalu_checker.sv
// port-level assertions for the packed datapath
// assumes binding onto psalu_top, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
`include "psalu_consts.vh"
module psalu_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic issue_valid,
    input wire logic [`PSALU_OP_W-1:0] issue_op,
    input wire logic [31:0] feature_word,
    input wire logic [63:0] mem_rdata,
    input wire logic [31:0] gpr_rdata,
    input wire logic done,
    input wire logic invalid_op,
    input wire logic [63:0] mem_wdata,
    input wire logic [7:0] mem_wbyte_en,
    input wire logic mem_wvalid,
    input wire logic gpr_wvalid,
    input wire logic [63:0] result,
    input wire logic status_flags_we,
    input wire logic exception
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic v = issue_valid && feature_word[`PSALU_FEATURE_BIT];
    a_one_answer: assert property (issue_valid |=>
        done != invalid_op)
        else $error("issue got no single answer");
    a_idle_quiet: assert property (!issue_valid |=>
        !done && !invalid_op)
        else $error("answer without issue");
    a_refuse_nofeat: assert property (issue_valid && !v |=>
        invalid_op && !mem_wvalid && !gpr_wvalid)
        else $error("op ran with feature bit low");
    a_flags_untouched: assert property (!status_flags_we)
        else $error("status flags written");
    a_no_exception: assert property (!exception)
        else $error("exception raised");
    a_store32_bytes: assert property (v &&
        issue_op == `PSALU_OP_MOVE_32_STORE |=>
        mem_wvalid && mem_wbyte_en == 8'h0f)
        else $error("32-bit store strobes wrong");
    a_store64_bytes: assert property (v &&
        issue_op == `PSALU_OP_MOVE_64_STORE |=>
        mem_wvalid && mem_wbyte_en == 8'hff)
        else $error("64-bit store strobes wrong");
    a_load64_copy: assert property (v &&
        issue_op == `PSALU_OP_MOVE_64_LOAD |=>
        done && result == $past(mem_rdata))
        else $error("64-bit load data wrong");
    a_load32_zero: assert property (v &&
        issue_op == `PSALU_OP_MOVE_32_LOAD |=>
        result == ($past(mem_rdata) & 64'h0000_0000_ffff_ffff))
        else $error("32-bit load data wrong");
    a_gpr_copy: assert property (v &&
        issue_op == `PSALU_OP_MOVE_32_FROM_GPR |=>
        result == {32'h0000_0000, $past(gpr_rdata)})
        else $error("move from gpr wrong");
    a_to_gpr_pulse: assert property (v &&
        issue_op == `PSALU_OP_MOVE_32_TO_GPR |=> gpr_wvalid && !mem_wvalid)
        else $error("move to gpr not signalled");
    c_store64: cover property (v && issue_op == `PSALU_OP_MOVE_64_STORE);
    c_refused: cover property (invalid_op);
    c_back_to_back: cover property (done [*2]);
endmodule
bind psalu_top psalu_checker u_psalu_checker (.clk_sys, .rst,
    .issue_valid, .issue_op, .feature_word, .mem_rdata, .gpr_rdata,
    .done, .invalid_op, .mem_wdata, .mem_wbyte_en, .mem_wvalid,
    .gpr_wvalid, .result, .status_flags_we, .exception);
`default_nettype wire

// File: tb/psalu_issue_model.sv
// decode and issue side: drives one op per falling edge
// assumes the bench calls issue and idle hierarchically
`timescale 1ns/1ps
`default_nettype none
module psalu_issue_model (
    input wire logic clk_sys,
    output logic issue_valid,
    output logic [4:0] issue_op,
    output logic [2:0] dst_idx,
    output logic [2:0] src_idx,
    output logic [31:0] feature_word,
    output logic [63:0] mem_rdata,
    output logic [31:0] gpr_rdata
);
    initial begin
        issue_valid = 1'b0;
        {issue_op, dst_idx, src_idx, feature_word} = 0;
        mem_rdata = 64'h0000_0000_0000_0000;
        gpr_rdata = 32'h0000_0000;
    end
    task automatic issue(input [4:0] op, input [2:0] d, s,
        input [63:0] m, input [31:0] g, input bit en);
        @(negedge clk_sys);
        issue_valid = 1'b1;
        issue_op = op;
        dst_idx = d;
        src_idx = s;
        feature_word = ($urandom & 32'hff7f_ffff) | {8'h00, en, 23'h00_0000};
        mem_rdata = m;
        gpr_rdata = g;
    endtask
    // released lines show the inverse
    task automatic idle();
        @(negedge clk_sys);
        issue_valid = 1'b0;
        mem_rdata = ~mem_rdata;
        gpr_rdata = ~gpr_rdata;
    endtask
endmodule
`default_nettype wire

// File: tb/tb_psalu_top.sv
// self-checking bench: corner tables then random ops
// assumes psalu_top, its checker and the issue model
`timescale 1ns/1ps
`default_nettype none
`include "psalu_consts.vh"
module tb_psalu_top;
    logic clk_sys, rst, issue_valid, done, invalid_op, mem_wvalid;
    logic gpr_wvalid, status_flags_we, exception;
    logic [4:0] issue_op;
    logic [2:0] dst_idx, src_idx;
    logic [31:0] feature_word, gpr_rdata, gpr_wdata;
    logic [63:0] mem_rdata, mem_wdata, result;
    logic [7:0] mem_wbyte_en;
    logic [63:0] rf [8];
    logic [63:0] pa [4];
    logic [63:0] pb [4];
    int fails, compares;
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    psalu_issue_model u_psalu_issue_model (.clk_sys, .issue_valid,
        .issue_op, .dst_idx, .src_idx, .feature_word, .mem_rdata,
        .gpr_rdata);
    psalu_top u_psalu_top (.clk_sys, .rst, .issue_valid, .issue_op,
        .dst_idx, .src_idx, .feature_word, .mem_rdata, .gpr_rdata, .done,
        .invalid_op, .mem_wdata, .mem_wbyte_en, .mem_wvalid, .gpr_wdata,
        .gpr_wvalid, .result, .status_flags_we, .exception);
    function automatic [63:0] calc(input [4:0] op, input [63:0] a, b, m,
        input [31:0] g);
        longint x, y, r, k, lo, hi, p;
        int w, md, i;
        logic [63:0] o;
        o = 0;
        w = (op inside {2, 5, 8, 10, 12, 14}) ? 16 :
            (op inside {3, 6}) ? 32 : 8;
        md = (op inside {[7:10]}) ? 1 : (op inside {[11:14]}) ? 2 : 0;
        k = longint'(1) << w;
        lo = (md == 1) ? -(k / 2) : 0;
        hi = (md == 1) ? k / 2 - 1 : k - 1;
        if (op <= 5'h0e) for (i = 0; i < 64; i += w) begin
            x = longint'(a >> i) & (k - 1);
            y = longint'(b >> i) & (k - 1);
            if (md == 1 && x >= k / 2) x -= k;
            if (md == 1 && y >= k / 2) y -= k;
            r = (op inside {4, 5, 6, 9, 10, 13, 14}) ? x - y : x + y;
            if (md != 0 && r > hi) r = hi;
            if (md != 0 && r < lo) r = lo;
            o |= 64'(r & (k - 1)) << i;
        end
        if (op >= 5'h0f && op <= 5'h11) for (i = 0; i < 4; i++) begin
            p = longint'($signed(a[i*16+:16])) *
                longint'($signed(b[i*16+:16]));
            if (op == 5'h0f) o[i*16+:16] = p[31:16];
            if (op == 5'h10) o[i*16+:16] = p[15:0];
            if (op == 5'h11) o[i/2*32+:32] += p[31:0];
        end
        if (op == 5'h12) o = {32'h0000_0000, m[31:0]};
        if (op == 5'h14) o = {32'h0000_0000, g};
        if (op == 5'h16) o = m;
        if (op == 5'h18) o = b;
        return o;
    endfunction
    task automatic chk(input [63:0] got, exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input [4:0] op, input [2:0] d, s, input [63:0] m,
        input bit en);
        logic [31:0] g;
        logic [63:0] e;
        bit ok;
        g = $urandom;
        ok = en && op >= 5'h01 && op <= 5'h18;
        e = calc(op, rf[d], rf[s], m, g);
        u_psalu_issue_model.issue(op, d, s, m, g, en);
        @(posedge clk_sys);
        #1;
        chk(done, ok);
        chk(invalid_op, !ok);
        chk({status_flags_we, exception}, 0);
        if (!ok) chk({mem_wvalid, gpr_wvalid}, 0);
        else if (op == 5'h13) chk(mem_wdata[31:0], rf[s][31:0]);
        else if (op == 5'h17) chk(mem_wdata, rf[s]);
        else if (op == 5'h15) chk(gpr_wdata, rf[s][31:0]);
        else begin
            chk(result, e);
            rf[d] = e;
        end
    endtask
    task automatic reset_all();
        int i;
        u_psalu_issue_model.idle();
        rst = 1'b1;
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        for (i = 0; i < 8; i++) rf[i] = `PSALU_REG_RESET;
        for (i = 0; i < 8; i++) run(5'h17, 0, 3'(i), 0, 1);
    endtask
    task automatic summarize();
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        summarize();
    end
    initial begin
        int c, op, n;
        fails = 0;
        compares = 0;
        rst = 1'b1;
        void'($urandom(70));
        pa = '{64'h7f80_ff00_7fff_8000, 64'h8000_7fff_0080_ff7f,
            {$urandom, $urandom}, {$urandom, $urandom}};
        pb = '{64'h0101_0101_0001_0001, 64'h7fff_8000_ff81_0180,
            {$urandom, $urandom}, {$urandom, $urandom}};
        reset_all();
        for (c = 0; c < 4; c++) for (op = 1; op <= 17; op++) begin
            run(5'h16, 3, 0, pa[c], 1);
            run(5'h16, 2, 0, pb[c], 1);
            run(5'(op), 3, 2, 0, 1);
        end
        for (n = 0; n < 800; n++)
            run(5'($urandom), 3'($urandom), 3'($urandom),
                {$urandom, $urandom}, ($urandom % 8) != 0);
        reset_all();
        u_psalu_issue_model.idle();
        summarize();
    end
endmodule
`default_nettype wire
